// >>> rtl/align_release_ctrl.sv
// Multiblock counter phase and elastic buffer release control, AXI4-Lite slave
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module align_release_ctrl
    import align_ctrl_pkg::*;
#(
    parameter int E = 1,
    parameter logic RESET_IMM_RELEASE = RST_IMM_RELEASE,
    parameter logic [8:0] RESET_REL_OFS = RST_REL_OFS,
    parameter logic [7:0] RESET_CNT_OFS = RST_CNT_OFS
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_pulse,
    input wire logic ref_detect_en,
    input wire logic [8:0] lane_delay_count,
    input wire logic lanes_aligned,
    output logic buffer_release,
    output logic [8:0] mb_count
);
    localparam int CW = 9;
    localparam logic [CW-1:0] LAST = CW'(E * 16 - 1);

    // Register decode on the word index; the two low address bits are ignored
    function automatic logic hits_reg(input logic [7:0] addr, input logic [7:0] reg_addr);
        return addr[7:2] == reg_addr[7:2];
    endfunction : hits_reg

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    logic imm_release;
    logic [8:0] rel_ofs;
    logic [7:0] cnt_ofs;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] ctrl_word;
    logic do_write;
    logic ctrl_wr_en;
    logic [31:0] status_word;

    // Read-back image of the control word; reserved bits read as zero
    assign ctrl_word = {6'h00, imm_release, rel_ofs, cnt_ofs, 8'h00};

    // Field writes only land on the control word
    assign ctrl_wr_en = do_write && hits_reg(aw_addr, ADDR_REF_ALIGN_CTRL);

    // Address and data may arrive in either order; hold each until both are in
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            // A taken half waits here for its partner
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // Write response one cycle after both halves are held
    // Writes to anything but the control word are refused with SLVERR
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= hits_reg(aw_addr, ADDR_REF_ALIGN_CTRL) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Immediate-release flag in the top byte lane; reset value fixed at build time
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            imm_release <= RESET_IMM_RELEASE;
        end else if (ctrl_wr_en && w_strb[3]) begin
            imm_release <= w_data[IMM_RELEASE_BIT];
        end
    end

    // Release offset straddles byte lanes two and three
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rel_ofs <= RESET_REL_OFS;
        end else if (ctrl_wr_en) begin
            if (w_strb[2]) begin
                rel_ofs[7:0] <= w_data[REL_OFS_LSB+7:REL_OFS_LSB];
            end
            if (w_strb[3]) begin
                rel_ofs[8] <= w_data[REL_OFS_MSB];
            end
        end
    end

    // Counter offset; the range fallback happens at the counter's load input
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ofs <= RESET_CNT_OFS;
        end else if (ctrl_wr_en && w_strb[1]) begin
            cnt_ofs <= w_data[CNT_OFS_MSB:CNT_OFS_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: one-cycle answer, unmapped reads SLVERR with zero data
    // One read outstanding: a new address waits until the data is taken
    assign s_axi_arready = !s_axi_rvalid;

    // Status word: release flag and live counter value
    assign status_word = {15'h0000, buffer_release, 7'h00, mb_count};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr[7:2])
                ADDR_REF_ALIGN_CTRL[7:2]: s_axi_rdata <= ctrl_word;
                ADDR_ALIGN_STATUS[7:2]: s_axi_rdata <= status_word;
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference pulse synchroniser and rising-edge detect
    // Pin is asynchronous: two flops settle it, the third only delays for the edge
    logic ref_s1, ref_s2, ref_s3;
    logic ref_rise;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
        end else begin
            ref_s1 <= ref_pulse;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
        end
    end

    // Mode gating is decided outside; this input qualifies edges
    assign ref_rise = ref_s2 && !ref_s3 && ref_detect_en;

    // Offsets above the counter range fall back to zero
    function automatic logic [CW-1:0] clamp_cnt_ofs(input logic [7:0] ofs);
        if (int'(ofs) > int'(LAST))
            return '0;
        return CW'(ofs);
    endfunction : clamp_cnt_ofs

    logic at_boundary;

    ////////////////////////////////////////////////////////////////////////////
    // Multiblock counter
    // Default offset zero makes each edge restart the counter at zero
    multiblock_counter #(
        .CW(CW)
    ) u_counter (
        .mclk(mclk),
        .arst_n(arst_n),
        .load(ref_rise),
        .load_value(clamp_cnt_ofs(cnt_ofs)),
        .last_value(LAST),
        .count(mb_count),
        .at_boundary(at_boundary)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Release point: offset counts link clocks before the boundary
    logic [8:0] eff_ofs;
    logic ofs_illegal;
    logic [CW-1:0] release_point;
    logic release_hit;

    // Immediate release borrows the measured lane delay as its offset
    assign eff_ofs = imm_release ? lane_delay_count : rel_ofs;
    // An offset beyond the count range can never match, so release at once
    assign ofs_illegal = (eff_ofs > LAST);
    assign release_point = LAST - eff_ofs;

    // Release point: the boundary itself for offset zero, else the count match
    assign release_hit = ofs_illegal
                         || (eff_ofs == 9'h000 && at_boundary)
                         || (eff_ofs != 9'h000 && mb_count == release_point);

    ////////////////////////////////////////////////////////////////////////////
    // Release sequence: idle until lanes arrive, armed until the point, then open
    typedef enum logic [1:0] {
        REL_IDLE,
        REL_ARMED,
        REL_OPEN
    } rel_state_t;
    rel_state_t state, next_state;

    // Losing alignment always drops back to idle and closes the buffer
    always_comb begin
        next_state = state;
        case (state)
            REL_IDLE: begin
                if (lanes_aligned && release_hit) begin
                    next_state = REL_OPEN;
                end else if (lanes_aligned) begin
                    next_state = REL_ARMED;
                end
            end
            REL_ARMED: begin
                if (!lanes_aligned) begin
                    next_state = REL_IDLE;
                end else if (release_hit) begin
                    next_state = REL_OPEN;
                end
            end
            REL_OPEN: begin
                if (!lanes_aligned) begin
                    next_state = REL_IDLE;
                end
            end
            default: begin
                next_state = REL_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state <= REL_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Release output moves with the state so it stays a plain flop
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            buffer_release <= 1'b0;
        end else begin
            buffer_release <= (next_state == REL_OPEN);
        end
    end
endmodule : align_release_ctrl

// >>> rtl/align_ctrl_pkg.sv
// Package: register map, field positions, reset values for alignment control
package align_ctrl_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_REF_ALIGN_CTRL = 8'h54;
    localparam logic [7:0] ADDR_RX_STATUS_WORD_ZERO = 8'h80;
    localparam logic [7:0] ADDR_ALIGN_STATUS = 8'h58;
    // Field positions of the control word
    localparam int IMM_RELEASE_BIT = 25;
    localparam int REL_OFS_MSB = 24;
    localparam int REL_OFS_LSB = 16;
    localparam int CNT_OFS_MSB = 15;
    localparam int CNT_OFS_LSB = 8;
    localparam int CNT_OFS_LIMIT = 255;
    // Build-time reset values of the compile-time specific fields
    localparam logic RST_IMM_RELEASE = 1'b0;
    localparam logic [8:0] RST_REL_OFS = 9'h000;
    localparam logic [7:0] RST_CNT_OFS = 8'h00;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : align_ctrl_pkg

// >>> rtl/multiblock_counter.sv
// Multiblock counter with reference-pulse reload
`timescale 1ns/1ns
module multiblock_counter #(
    parameter int CW = 9
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [CW-1:0] load_value,
    input wire logic [CW-1:0] last_value,
    output logic [CW-1:0] count,
    output logic at_boundary
);
    // Reload on reference edge, otherwise count and wrap at the last value
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (count >= last_value) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    assign at_boundary = (count == last_value);
endmodule : multiblock_counter

// >>> testbench/align_release_ctrl_asserts.sv
// Checker for counter, release and bus timing
`timescale 1ns/1ns
module align_release_ctrl_asserts #(
    parameter int E = 1
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ref_pulse,
    input wire logic lanes_aligned,
    input wire logic buffer_release,
    input wire logic [8:0] mb_count
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic [3:0] quiet;
    // Quiet time since the pin was high; a reload lands within a few cycles
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) quiet <= 4'h0;
        else if (ref_pulse) quiet <= 4'h0;
        else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end
    a_count_range: assert property (mb_count <= 9'(E * 16 - 1))
        else $error("count out of range");
    a_count_step: assert property (quiet > 4'h8 |-> mb_count ==
        ($past(mb_count) == 9'(E * 16 - 1) ? 9'h000 : $past(mb_count) + 9'h001))
        else $error("count step wrong");
    a_release_drop: assert property (!lanes_aligned |=> !buffer_release)
        else $error("release without lanes");
    a_release_cause: assert property ($rose(buffer_release) |-> $past(lanes_aligned))
        else $error("release rose early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    c_release: cover property ($rose(buffer_release));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_reload: cover property ($fell(ref_pulse));
endmodule : align_release_ctrl_asserts
bind align_release_ctrl align_release_ctrl_asserts #(.E(E)) chk_u (
    .mclk, .arst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .ref_pulse, .lanes_aligned, .buffer_release, .mb_count
);

// >>> testbench/ref_lane_model.sv
// Reference pulse source and lane datapath stand-in
`timescale 1ns/1ns
module ref_lane_model (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic pulse_req,
    input wire logic align_req,
    input wire logic [8:0] delay_req,
    output logic ref_pulse,
    output logic ref_detect_en,
    output logic [8:0] lane_delay_count,
    output logic lanes_aligned
);
    // Pin is a level; a two-cycle request keeps it wide enough to synchronise
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ref_pulse <= 1'b0;
            lanes_aligned <= 1'b0;
            lane_delay_count <= 9'h000;
        end else begin
            ref_pulse <= pulse_req;
            lanes_aligned <= align_req;
            lane_delay_count <= delay_req;
        end
    end
    assign ref_detect_en = 1'b1;
endmodule : ref_lane_model

// >>> testbench/align_release_ctrl_tb.sv
// Self-checking bench for alignment and release control
`timescale 1ns/1ns
module align_release_ctrl_tb;
    import align_ctrl_pkg::*;
    logic mclk = 1'b0, arst_n = 1'b0, pulse_req = 1'b0, align_req = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, hit;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic ref_pulse, ref_detect_en, lanes_aligned, buffer_release;
    logic [8:0] lane_delay_count, mb_count, rel_cnt;
    int num_errors = 0, total_checks = 0, cycles = 0, n;
    align_release_ctrl #(.E(1)) dut_u (.*);
    ref_lane_model far_u (.mclk, .arst_n, .pulse_req, .align_req, .delay_req(9'h003),
        .ref_pulse, .ref_detect_en, .lane_delay_count, .lanes_aligned);
    initial forever #5 mclk = ~mclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // Bus cycles: each channel is released only at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) {rsp, s_axi_bready} <= {s_axi_bresp, 1'b0};
        end while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
    endtask : wr
    task automatic rdt(input logic [7:0] a);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) {rd, rsp, s_axi_rready} <= {s_axi_rdata, s_axi_rresp, 1'b0};
        end while (s_axi_arvalid || s_axi_rready);
    endtask : rdt
    // Lanes arrive, then the count at the first released cycle is kept
    task automatic rel(input logic [31:0] ctrl);
        wr(ADDR_REF_ALIGN_CTRL, ctrl);
        align_req <= 1'b1;
        n = 0;
        do begin @(posedge mclk); n++; end while (buffer_release !== 1'b1);
        rel_cnt = mb_count;
        rdt(ADDR_ALIGN_STATUS);
        chk({rd[31:9], 9'h000}, 32'h0001_0000, "status release");
        align_req <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask : rel
    // Pulse at count exp+7 so free counting cannot reach exp in the window
    task automatic load(input logic [31:0] ctrl, input logic [8:0] exp);
        wr(ADDR_REF_ALIGN_CTRL, ctrl);
        do @(posedge mclk); while (mb_count !== ((exp + 9'h007) & 9'h00f));
        pulse_req <= 1'b1;
        hit = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            if (i == 1) pulse_req <= 1'b0;
            if (mb_count === exp) hit = 1'b1;
        end
        chk({31'h0, hit}, 32'h1, "counter load");
    endtask : load
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rdt(ADDR_REF_ALIGN_CTRL);
        chk(rd, 32'h0, "ctrl reset");
        wr(ADDR_REF_ALIGN_CTRL, 32'hffff_ffff);
        chk({30'h0, rsp}, {30'h0, RESP_OKAY}, "write resp");
        rdt(ADDR_REF_ALIGN_CTRL);
        chk(rd, 32'h03ff_ff00, "ctrl fields");
        rdt(8'h40);
        chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR}, "unmapped");
        wr(8'h40, 32'h0000_0000);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR}, "write unmapped");
        rdt(ADDR_REF_ALIGN_CTRL);
        chk(rd, 32'h03ff_ff00, "ctrl kept");
        load(32'h0000_0500, 9'h005);
        load(32'h0000_0000, 9'h000);
        load(32'h0000_c800, 9'h000);
        rel(32'h0000_0000);
        chk(32'(rel_cnt), 32'h0, "release zero");
        rel(32'h0005_0000);
        chk(32'(rel_cnt), 32'hb, "release five");
        rel(32'h000f_0000);
        chk(32'(rel_cnt), 32'h1, "release last");
        rel(32'h0200_0000);
        chk(32'(rel_cnt), 32'hd, "release lane delay");
        rel(32'h0014_0000);
        chk({31'h0, n <= 4}, 32'h1, "release out of range");
        close_out();
    end
endmodule : align_release_ctrl_tb
